// ---- rtl/agu_pkg.sv ----
//----------------------------------------------------------------
// Operation
//----------------------------------------------------------------
package agu_pkg;
	localparam int ADDR_W = 32;
	localparam int NUM_GPR = 32;
	localparam int REG_IDX_W = 5;
	localparam int NUM_REGION = 32;
	localparam int REGION_SHIFT = 27;
	localparam int ATTR_W = 6;
	localparam logic [ADDR_W-1:0] INSN_STEP = 32'h0000_0004;
	localparam logic [ADDR_W-1:0] RESET_PC = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] GPR_RESET = 32'h0000_0000;
	localparam logic [ATTR_W-1:0] ATTR_RESET = 6'h00;

	typedef enum logic [1:0] {
		AGU_DM_NONE = 2'h0,
		AGU_DM_IMM = 2'h1,
		AGU_DM_IDX = 2'h3,
		AGU_DM_IND = 2'h2
	} agu_dmode_t;

	typedef enum logic [2:0] {
		AGU_BR_SEQ = 3'h0,
		AGU_BR_REL = 3'h1,
		AGU_BR_ABS = 3'h3,
		AGU_BR_LR = 3'h2,
		AGU_BR_CTR = 3'h6
	} agu_bmode_t;

	typedef struct packed {
		agu_dmode_t mode;
		logic update;
		logic store;
		logic [REG_IDX_W-1:0] base_idx;
		logic [REG_IDX_W-1:0] index_idx;
		logic [ADDR_W-1:0] disp;
	} agu_dreq_t;

	typedef struct packed {
		logic valid;
		logic store;
		logic translate;
		logic [ADDR_W-1:0] addr;
		logic [ATTR_W-1:0] storage_attribute_set;
	} agu_dout_t;

	// storage attributes: write-through, cacheable, user0, guarded, endian, spare
	function automatic logic [ADDR_W-1:0] agu_add(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] b);
		logic [ADDR_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		agu_add = s[ADDR_W-1:0];
	endfunction
endpackage

// ---- rtl/agu_top.sv ----
`timescale 1ns/1ps
module agu_top
	import agu_pkg::*;
(
	input wire logic I_SYS_CLK, // core clock
	input wire logic I_SYS_RST, // sync reset, high
	input wire logic i_privileged, // 1 privileged, 0 user
	input wire logic i_virtual, // 1 virtual, 0 real
	input wire logic i_gpr_we, // write-back port enable
	input wire logic [REG_IDX_W-1:0] i_gpr_widx, // write-back index
	input wire logic [ADDR_W-1:0] i_gpr_wdata, // write-back data
	input wire logic i_lr_we, // link register write
	input wire logic [ADDR_W-1:0] i_lr_wdata, // link register data
	input wire logic i_ctr_we, // count register write
	input wire logic [ADDR_W-1:0] i_ctr_wdata, // count register data
	input wire logic i_attr_we, // region attribute write
	input wire logic [REG_IDX_W-1:0] i_attr_widx, // region index
	input wire logic [ATTR_W-1:0] i_attr_wdata, // attribute value
	input wire logic i_dvalid, // data request valid
	input wire agu_dreq_t i_dreq, // data request
	input wire logic i_advance, // next instruction step
	input wire agu_bmode_t i_bmode, // branch mode
	input wire logic [ADDR_W-1:0] i_bdisp, // branch displacement
	output agu_dout_t o_dout, // data address to load/store
	output logic [ADDR_W-1:0] o_pc, // current instruction address
	output logic o_priv_fault // privileged write refused
);
	//----------------------------------------------------------------
	// state
	//----------------------------------------------------------------
	logic [ADDR_W-1:0] gpr [NUM_GPR];
	logic [ATTR_W-1:0] attr [NUM_REGION];
	logic [ADDR_W-1:0] lr;
	logic [ADDR_W-1:0] ctr;
	logic [ADDR_W-1:0] pc;

	//----------------------------------------------------------------
	// data address
	//----------------------------------------------------------------
	wire logic [ADDR_W-1:0] base_val = gpr[i_dreq.base_idx];
	wire logic [ADDR_W-1:0] index_val = gpr[i_dreq.index_idx];
	wire logic [ADDR_W-1:0] ea_imm = agu_add(base_val, i_dreq.disp);
	wire logic [ADDR_W-1:0] ea_idx = agu_add(base_val, index_val);
	wire logic [ADDR_W-1:0] ea_ind = base_val;
	wire logic [ADDR_W-1:0] next_ea = (i_dreq.mode == AGU_DM_IMM) ? ea_imm :
		(i_dreq.mode == AGU_DM_IDX) ? ea_idx : ea_ind;
	wire logic d_go = i_dvalid && (i_dreq.mode != AGU_DM_NONE);
	// update only exists for the immediate-displacement and indexed forms
	wire logic upd_go = d_go && i_dreq.update &&
		(i_dreq.mode == AGU_DM_IMM || i_dreq.mode == AGU_DM_IDX);
	wire logic [REG_IDX_W-1:0] region = next_ea[ADDR_W-1:REGION_SHIFT];

	//----------------------------------------------------------------
	// privilege: attribute controls are privileged-only
	//----------------------------------------------------------------
	wire logic attr_ok = i_attr_we && i_privileged;
	wire logic attr_blocked = i_attr_we && !i_privileged;

	//----------------------------------------------------------------
	// next instruction address
	//----------------------------------------------------------------
	logic [ADDR_W-1:0] next_pc;
	always_comb begin
		case (i_bmode)
			AGU_BR_REL: next_pc = agu_add(pc, i_bdisp);
			AGU_BR_ABS: next_pc = i_bdisp;
			AGU_BR_LR: next_pc = lr;
			AGU_BR_CTR: next_pc = ctr;
			default: next_pc = agu_add(pc, INSN_STEP);
		endcase
	end

	//----------------------------------------------------------------
	// registers
	//----------------------------------------------------------------
	// update write-back wins over the external port when both hit one register
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			for (int k = 0; k < NUM_GPR; k++) begin
				gpr[k] <= GPR_RESET;
			end
		end else begin
			if (i_gpr_we) begin
				gpr[i_gpr_widx] <= i_gpr_wdata;
			end
			if (upd_go) begin
				gpr[i_dreq.base_idx] <= next_ea;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			for (int k = 0; k < NUM_REGION; k++) begin
				attr[k] <= ATTR_RESET;
			end
		end else if (attr_ok) begin
			attr[i_attr_widx] <= i_attr_wdata;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			lr <= GPR_RESET;
			ctr <= GPR_RESET;
			pc <= RESET_PC;
		end else begin
			if (i_lr_we) begin
				lr <= i_lr_wdata;
			end
			if (i_ctr_we) begin
				ctr <= i_ctr_wdata;
			end
			if (i_advance) begin
				pc <= next_pc;
			end
		end
	end

	//----------------------------------------------------------------
	// outputs
	//----------------------------------------------------------------
	// attributes apply only in real mode; virtual path leaves them to translation
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			o_dout <= '0;
			o_priv_fault <= 1'b0;
		end else begin
			o_dout.valid <= d_go;
			o_dout.store <= i_dreq.store;
			o_dout.addr <= next_ea;
			o_dout.translate <= i_virtual;
			o_dout.storage_attribute_set <= i_virtual ? ATTR_RESET : attr[region];
			o_priv_fault <= attr_blocked;
		end
	end

	assign o_pc = pc;
endmodule

// ---- tb/address_generation_unit_tb_top.sv ----
`timescale 1ns/1ps
module address_generation_unit_tb_top;
	import agu_pkg::*;
	logic I_SYS_CLK = 0, I_SYS_RST = 1, i_privileged = 0, i_virtual = 0, i_dvalid = 0;
	logic i_gpr_we = 0, i_lr_we = 0, i_ctr_we = 0, i_attr_we = 0, i_advance = 0;
	logic [4:0] i_gpr_widx = 0, i_attr_widx = 0;
	logic [31:0] i_gpr_wdata = 0, i_lr_wdata = 0, i_ctr_wdata = 0, i_bdisp = 0;
	logic [5:0] i_attr_wdata = 0;
	agu_dreq_t i_dreq = '0;
	agu_bmode_t i_bmode = AGU_BR_SEQ;
	agu_dout_t o_dout, ed = '0;
	logic [31:0] o_pc, last, r, s, ea, lr = 0, ctr = 0, epc = 0, elast = 0;
	logic [31:0] gpr[32] = '{default: 0};
	logic [5:0] attr[32] = '{default: 0};
	logic o_priv_fault, ef = 0;
	int err_count = 0, n_tests = 0, seed = 9;
	agu_bmode_t bt[5] = '{AGU_BR_SEQ, AGU_BR_REL, AGU_BR_ABS, AGU_BR_LR, AGU_BR_CTR};
	agu_top dut (.*);
	agu_lsu_model lsu (.i_clk(I_SYS_CLK), .i_rst(I_SYS_RST), .i_dout(o_dout), .o_last(last));
	task cmp(input logic [40:0] g, input logic [40:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task conclude;
		if (err_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial forever #50 I_SYS_CLK = ~I_SYS_CLK;
	initial begin
		repeat (2) @(posedge I_SYS_CLK);
		I_SYS_RST <= 0;
		for (int k = 0; k < 2000; k++) begin
			@(posedge I_SYS_CLK);
			r = $random(seed);
			s = $random(seed);
			{i_privileged, i_virtual, i_dvalid, i_advance} <= r[3:0];
			// gpr and attr writes kept off i_virtual cycles, lr and ctr writes off i_privileged cycles
			{i_gpr_we, i_attr_we} <= {r[4], r[7]} & {2{~r[2]}};
			{i_lr_we, i_ctr_we} <= r[6:5] & {2{~r[3]}};
			{i_gpr_widx, i_attr_widx, i_attr_wdata} <= r[23:8];
			{i_gpr_wdata, i_lr_wdata, i_ctr_wdata} <= {s, ~s, s ^ r};
			i_bmode <= bt[r[31:24] % 5];
			i_bdisp <= k % 16 ? $random(seed) : 32'hFFFF_FFFC;
			i_dreq <= {$random(seed), s[13:0]};
			@(negedge I_SYS_CLK);
			cmp(ed.valid ? o_dout : o_dout.valid, ed);
			cmp(o_pc, epc);
			cmp(o_priv_fault, ef);
			cmp(last, elast);
			if (ed.valid)
				elast = ed.addr;
			ef = i_attr_we & ~i_privileged;
			ea = gpr[i_dreq.base_idx];
			if (i_dreq.mode == AGU_DM_IMM)
				ea = ea + i_dreq.disp;
			if (i_dreq.mode == AGU_DM_IDX)
				ea = ea + gpr[i_dreq.index_idx];
			ed = '0;
			if (i_dvalid && i_dreq.mode != AGU_DM_NONE)
				ed = {3'h4 | {i_dreq.store, i_virtual}, ea, i_virtual ? 6'h00 : attr[ea[31:27]]};
			if (i_advance)
				epc = i_bmode == AGU_BR_REL ? epc + i_bdisp : i_bmode == AGU_BR_ABS ? i_bdisp :
					i_bmode == AGU_BR_LR ? lr : i_bmode == AGU_BR_CTR ? ctr : epc + INSN_STEP;
			if (i_gpr_we)
				gpr[i_gpr_widx] = i_gpr_wdata;
			if (ed.valid && i_dreq.update && i_dreq.mode != AGU_DM_IND)
				gpr[i_dreq.base_idx] = ea;
			lr = i_lr_we ? i_lr_wdata : lr;
			ctr = i_ctr_we ? i_ctr_wdata : ctr;
			if (i_attr_we && i_privileged)
				attr[i_attr_widx] = i_attr_wdata;
		end
		conclude();
	end
endmodule
bind agu_top agu_monitor mon (.*);

// ---- tb/agu_lsu_model.sv ----
`timescale 1ns/1ps
module agu_lsu_model
	import agu_pkg::*;
(
	input wire logic i_clk, // clock
	input wire logic i_rst, // sync reset, high
	input wire agu_dout_t i_dout, // access
	output logic [ADDR_W-1:0] o_last // last address
);
	// reset keeps the last-address record known before the first access
	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_last <= 32'h0000_0000;
		else if (i_dout.valid)
			o_last <= i_dout.addr;
	end
endmodule

// ---- tb/agu_monitor.sv ----
`timescale 1ns/1ps
module agu_monitor
	import agu_pkg::*;
(
	input wire logic I_SYS_CLK, // clock
	input wire logic I_SYS_RST, // reset
	input wire logic i_privileged, // mode
	input wire logic i_virtual, // mode
	input wire logic i_attr_we, // attr write
	input wire logic i_dvalid, // request
	input wire agu_dreq_t i_dreq, // request
	input wire logic i_advance, // step
	input wire agu_bmode_t i_bmode, // branch
	input wire logic [ADDR_W-1:0] i_bdisp, // disp
	input wire agu_dout_t o_dout, // data out
	input wire logic [ADDR_W-1:0] o_pc, // pc
	input wire logic o_priv_fault // fault
);
	//----
	// checks
	//----
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_SYS_RST);
	chk_seq_step: assert property (i_advance && i_bmode == AGU_BR_SEQ
		|=> o_pc == $past(o_pc) + INSN_STEP) else $error("seq step");
	chk_rel_target: assert property (i_advance && i_bmode == AGU_BR_REL
		|=> o_pc == $past(o_pc) + $past(i_bdisp)) else $error("rel target");
	chk_abs_target: assert property (i_advance && i_bmode == AGU_BR_ABS
		|=> o_pc == $past(i_bdisp)) else $error("abs target");
	chk_pc_hold: assert property (!i_advance |=> $stable(o_pc)) else $error("pc moved");
	chk_req_valid: assert property (i_dvalid && i_dreq.mode != AGU_DM_NONE
		|=> o_dout.valid && o_dout.store == $past(i_dreq.store)) else $error("no valid");
	chk_idle_quiet: assert property (!i_dvalid || i_dreq.mode == AGU_DM_NONE
		|=> !o_dout.valid) else $error("stray valid");
	chk_xlate_mode: assert property (o_dout.valid
		|-> o_dout.translate == $past(i_virtual)) else $error("translate");
	chk_virt_noattr: assert property (o_dout.valid && o_dout.translate
		|-> o_dout.storage_attribute_set == 6'h00) else $error("attr virt");
	chk_priv_fault: assert property (o_priv_fault ==
		$past(i_attr_we && !i_privileged)) else $error("fault");
endmodule
